/* File: design/rsr_pkg.sv */
/*
  rsr_pkg: constants, state enum and state struct for the reset and
  stop-mode recovery controller.
  assumes: a 25 MHz system clock and a 4-bit AXI4-Lite byte address.
*/
package rsr_pkg;

  // clock and timing
  localparam int CLK_MHZ     = 25;
  localparam int SEQ_NS      = 2000;
  localparam int REC_NS      = 1000;
  localparam int WAKE_MIN_NS = 200;
  localparam int SEQ_CYC  = (SEQ_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC  = (REC_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SEQ_LAST  = 8'(SEQ_CYC - 1);
  localparam logic [7:0] REC_LAST  = 8'(REC_CYC - 1);
  localparam logic [7:0] WAKE_LAST = 8'(WAKE_CYC - 1);

  // register byte offsets
  localparam int         ADDR_W   = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_PIN  = 4'h8;
  localparam logic [3:0] OFS_MODE = 4'hC;

  // reset_cause_status bit positions
  localparam int B_POR  = 0;
  localparam int B_STOP = 1;
  localparam int B_WDT  = 2;
  localparam int B_EXT  = 3;
  localparam logic [3:0] CAUSE_RST = 4'h1;

  // synchronised misc input positions
  localparam int M_BO   = 0;
  localparam int M_POR  = 1;
  localparam int M_EXTN = 2;
  localparam int M_DBG  = 3;
  localparam int M_WDT  = 4;
  localparam logic [4:0] MISC_RST = 5'h0C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD, ST_SEQ, ST_ACTIVE, ST_HALT, ST_STOP, ST_RECOVER
  } rsr_state_e;

  typedef struct packed {
    rsr_state_e  st;
    logic [7:0]  cnt;
    logic [3:0]  cause;
    logic [3:0]  status;
    logic [7:0]  wakeEn;
    logic [7:0]  perDis;
    logic [7:0]  s1Pin;
    logic [7:0]  s2Pin;
    logic [7:0]  refPin;
    logic [4:0]  s1Misc;
    logic [4:0]  s2Misc;
    logic [7:0]  latch;
    logic        wdtWake;
    logic        irqReq;
    logic        sysRst;
    logic        cpuClkEn;
    logic [7:0]  perPwr;
    logic        boEn;
    logic        wdtRun;
    logic        stopOut;
    logic        haltOut;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awHave;
    logic        wHave;
    logic [3:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
  } rsr_state_s;

endpackage

/* File: design/rsr_ctrl.sv */
/*
  rsr_ctrl: reset and stop-mode recovery controller with an AXI4-Lite
  register slave (control, cause status, port latch, mode).
  assumes: supply detectors, reset pin, debug pin, gpio pins and the
  watchdog time-out are asynchronous; cpu strobes share clk.
*/
// The AXI4-Lite slave port and the address map are this design's own decisions.
// Behaviour
// - supply below trip level sends the device into reset.
// - reset is held while supply stays under power_on_threshold.
// - supply back above threshold runs the full reset sequence.
// - finished power-on reset sets the power-on cause flag.
// - option bit keeps or stops the supply_dip_guard during stop.
// - every sleep_wake_recovery sets the stop cause flag.
// - reset-mode watchdog time-out in stop gives recovery, not reset.
// - interrupt-mode watchdog wake requests interrupt only if enabled.
// - watchdog wake sets watchdog_cause_flag and stop cause flag.
// - watchdog interrupt is raised only after recovery completes.
// - each gpio pin can be enabled alone as a wake source.
// - any level change on an enabled pin starts recovery.
// - external reset pin in stop gives full system reset.
// - debug pin low in stop gives full system reset.
// - too-short wake pulse does not wake but sets stop flag.
// - port_input_latch does not sample pins during stop.
// - latch takes pin level only if it lasts to recovery end.
// - stop powers down nearly everything, deepest saving.
// - halt powers down only the processor.
// - other states are active; peripherals may be disabled there.
// - the stop instruction enters stop mode.
// - enabled watchdog keeps counting during stop.
`timescale 1ns/1ps

module rsr_ctrl
  import rsr_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // supply detectors and option
  input  wire logic              brownoutLow,
  input  wire logic              porLow,
  input  wire logic              brownoutInSleepOption,
  // pins
  input  wire logic              extResetN,
  input  wire logic              debugPin,
  input  wire logic [7:0]        gpioPin,
  // cpu and watchdog
  input  wire logic              stopInstr,
  input  wire logic              haltInstr,
  input  wire logic              haltWake,
  input  wire logic              watchdogEnable,
  input  wire logic              watchdogIrqMode,
  input  wire logic              irqEnable,
  input  wire logic              watchdogTimeout,
  // control outputs
  output logic                   sysReset,
  output logic                   cpuClockEn,
  output logic [7:0]             periphPowerEn,
  output logic                   brownoutEnable,
  output logic                   watchdogRun,
  output logic                   stopMode,
  output logic                   haltMode,
  output logic                   watchdogIrqReq,
  output logic [7:0]             portInputLatch
);

  rsr_state_s r;
  rsr_state_s n;
  logic [3:0] setB;
  logic [3:0] clrB;
  logic [2:0] wSel;
  logic [2:0] rSel;
  logic [7:0] diff;
  logic       supplyLow;
  logic       detOn;
  logic       stopClear;
  logic       seqDone;

  // {hit, index}
  function automatic logic [2:0] regSel(input logic [3:0] a);
    case (a)
      OFS_CTRL: regSel = 3'h4;
      OFS_STAT: regSel = 3'h5;
      OFS_PIN:  regSel = 3'h6;
      OFS_MODE: regSel = 3'h7;
      default:  regSel = 3'h0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////

  always_comb begin
    n = r;
    setB = 4'h0;
    clrB = 4'h0;
    seqDone = 1'b0;
    n.irqReq = 1'b0;
    n.s1Pin = gpioPin;
    n.s2Pin = r.s1Pin;
    n.s1Misc = {watchdogTimeout, debugPin, extResetN, porLow, brownoutLow};
    n.s2Misc = r.s1Misc;
    supplyLow = r.s2Misc[M_BO] | r.s2Misc[M_POR];
    detOn = (r.st != ST_STOP) | brownoutInSleepOption;
    stopClear = !(detOn && supplyLow) && r.s2Misc[M_EXTN] &&
                r.s2Misc[M_DBG];
    diff = (r.s2Pin ^ r.refPin) & r.wakeEn;
    wSel = regSel(r.awAddr);
    rSel = regSel(araddr);

    // write channel
    if (awvalid && r.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && r.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.awHave && r.wHave) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wSel[2] ? RESP_OKAY : RESP_SLVERR;
      if (wSel == 3'h4) begin
        if (r.wStrb[0]) begin
          n.wakeEn = r.wData[7:0];
        end
        if (r.wStrb[1]) begin
          n.perDis = r.wData[15:8];
        end
      end
      if (wSel == 3'h5 && r.wStrb[0]) begin
        clrB = r.wData[3:0];
      end
    end
    n.awready = !n.awHave && !n.bvalid;
    n.wready = !n.wHave && !n.bvalid;
    // read channel
    if (arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = rSel[2] ? RESP_OKAY : RESP_SLVERR;
      case (rSel)
        3'h4:    n.rdata = {16'h0000, r.perDis, r.wakeEn};
        3'h5:    n.rdata = {28'h000_0000, r.status};
        3'h6:    n.rdata = {24'h00_0000, r.latch};
        3'h7:    n.rdata = {29'h0000_0000, r.st};
        default: n.rdata = 32'h0000_0000;
      endcase
    end else if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;

    // mode sequencing
    if (detOn && supplyLow) begin
      n.st = ST_HOLD;
      n.cnt = 8'h00;
      n.cause = CAUSE_RST;
    end else begin
      case (r.st)
        ST_HOLD: begin
          n.st = ST_SEQ;
          n.cnt = 8'h00;
        end
        ST_SEQ: begin
          if (!r.s2Misc[M_EXTN]) begin
            n.cnt = 8'h00;
          end else if (r.cnt == SEQ_LAST) begin
            n.st = ST_ACTIVE;
            n.cnt = 8'h00;
            seqDone = 1'b1;
          end else begin
            n.cnt = r.cnt + 8'h01;
          end
        end
        ST_ACTIVE: begin
          n.latch = r.s2Pin;
          if (!r.s2Misc[M_EXTN]) begin
            n.st = ST_SEQ;
            n.cnt = 8'h00;
            n.cause = 4'h8;
          end else if (stopInstr) begin
            n.st = ST_STOP;
            n.cnt = 8'h00;
            n.refPin = r.s2Pin;
            n.wdtWake = 1'b0;
          end else if (haltInstr) begin
            n.st = ST_HALT;
          end
        end
        ST_HALT: begin
          n.latch = r.s2Pin;
          if (!r.s2Misc[M_EXTN]) begin
            n.st = ST_SEQ;
            n.cnt = 8'h00;
            n.cause = 4'h8;
          end else if (haltWake) begin
            n.st = ST_ACTIVE;
          end
        end
        ST_STOP: begin
          if (!r.s2Misc[M_EXTN] || !r.s2Misc[M_DBG]) begin
            n.st = ST_SEQ;
            n.cnt = 8'h00;
            n.cause = 4'h8;
          end else if (r.s2Misc[M_WDT]) begin
            n.st = ST_RECOVER;
            n.cnt = 8'h00;
            n.wdtWake = 1'b1;
            setB[B_WDT] = 1'b1;
          end else if (diff != 8'h00) begin
            if (r.cnt == WAKE_LAST) begin
              n.st = ST_RECOVER;
              n.cnt = 8'h00;
            end else begin
              n.cnt = r.cnt + 8'h01;
            end
          end else if (r.cnt != 8'h00) begin
            setB[B_STOP] = 1'b1;
            n.cnt = 8'h00;
          end
        end
        ST_RECOVER: begin
          if (r.cnt == REC_LAST) begin
            n.st = ST_ACTIVE;
            n.cnt = 8'h00;
            setB[B_STOP] = 1'b1;
            n.latch = r.s2Pin;
            n.irqReq = r.wdtWake && watchdogIrqMode && irqEnable;
          end else begin
            n.cnt = r.cnt + 8'h01;
          end
        end
        default: begin
          n.st = ST_SEQ;
          n.cnt = 8'h00;
        end
      endcase
    end

    // set wins over software clear
    if (seqDone) begin
      n.status = r.cause | setB;
    end else begin
      n.status = (r.status & ~clrB) | setB;
    end
    // power and clock controls
    n.sysRst = (n.st == ST_HOLD) || (n.st == ST_SEQ);
    n.cpuClkEn = (n.st == ST_ACTIVE);
    n.stopOut = (n.st == ST_STOP);
    n.haltOut = (n.st == ST_HALT);
    if (n.st == ST_ACTIVE || n.st == ST_HALT) begin
      n.perPwr = ~n.perDis;
    end else begin
      n.perPwr = 8'h00;
    end
    n.boEn = (n.st != ST_STOP) || brownoutInSleepOption;
    n.wdtRun = watchdogEnable;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ST_SEQ;
      r.cause <= CAUSE_RST;
      r.s1Misc <= MISC_RST;
      r.s2Misc <= MISC_RST;
      r.sysRst <= 1'b1;
      r.boEn <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign sysReset = r.sysRst;
  assign cpuClockEn = r.cpuClkEn;
  assign periphPowerEn = r.perPwr;
  assign brownoutEnable = r.boEn;
  assign watchdogRun = r.wdtRun;
  assign stopMode = r.stopOut;
  assign haltMode = r.haltOut;
  assign watchdogIrqReq = r.irqReq;
  assign portInputLatch = r.latch;

  //////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_bo_reset: assert property (
    r.s2Misc[M_BO] && r.st != ST_STOP |=> sysReset && r.st == ST_HOLD)
    else $error("brownout did not reset");
  a_por_hold: assert property (
    r.s2Misc[M_POR] && r.st != ST_STOP |=> sysReset)
    else $error("reset not held below threshold");
  a_seq_end: assert property (
    $fell(sysReset) |-> $past(r.st) == ST_SEQ && $past(r.cnt) == SEQ_LAST)
    else $error("reset released outside full sequence");
  a_por_flag: assert property (
    $fell(sysReset) && $past(r.cause[B_POR]) |-> r.status[B_POR])
    else $error("power-on flag missing");
  a_bo_sleep: assert property (
    stopMode |-> brownoutEnable == $past(brownoutInSleepOption))
    else $error("brownout enable wrong in stop");
  a_stop_flag: assert property (
    r.st == ST_RECOVER && r.cnt == REC_LAST && !supplyLow
    |=> r.status[B_STOP] && cpuClockEn)
    else $error("stop flag missing after recovery");
  a_wdt_wake: assert property (
    r.st == ST_STOP && stopClear && r.s2Misc[M_WDT]
    |=> r.st == ST_RECOVER && !sysReset && r.status[B_WDT])
    else $error("watchdog wake wrong");
  a_irq_gate: assert property (
    watchdogIrqReq |-> $past(watchdogIrqMode && irqEnable && r.wdtWake))
    else $error("watchdog irq without enable");
  a_irq_after: assert property (
    watchdogIrqReq |-> $past(r.st) == ST_RECOVER && r.st == ST_ACTIVE)
    else $error("watchdog irq before recovery end");
  a_pin_wake: assert property (
    (r.st == ST_STOP && stopClear && !r.s2Misc[M_WDT] &&
     diff != 8'h00 && r.cnt == 8'h00) ##1
    (r.st == ST_STOP && stopClear && !r.s2Misc[M_WDT] &&
     diff != 8'h00)[*4] |=> r.st == ST_RECOVER)
    else $error("pin change did not wake");
  a_ext_stop: assert property (
    r.st == ST_STOP && !(detOn && supplyLow) && !r.s2Misc[M_EXTN]
    |=> sysReset)
    else $error("reset pin in stop did not reset");
  a_dbg_stop: assert property (
    r.st == ST_STOP && !(detOn && supplyLow) && !r.s2Misc[M_DBG]
    |=> sysReset)
    else $error("debug low in stop did not reset");
  a_short_pulse: assert property (
    r.st == ST_STOP && stopClear && !r.s2Misc[M_WDT] &&
    diff == 8'h00 && r.cnt != 8'h00 |=> r.status[B_STOP] && stopMode)
    else $error("short pulse handling wrong");
  a_latch_frozen: assert property (
    r.st == ST_STOP |=> $stable(portInputLatch))
    else $error("latch sampled in stop");
  a_latch_end: assert property (
    r.st == ST_RECOVER && r.cnt == REC_LAST && !supplyLow
    |=> portInputLatch == $past(r.s2Pin))
    else $error("latch not captured at recovery end");
  a_stop_power: assert property (
    stopMode |-> !cpuClockEn && periphPowerEn == 8'h00)
    else $error("stop left power on");
  a_halt_power: assert property (
    haltMode |-> !cpuClockEn && periphPowerEn == ~r.perDis)
    else $error("halt power wrong");
  a_active_power: assert property (
    cpuClockEn |-> periphPowerEn == ~r.perDis && !stopMode && !haltMode)
    else $error("active peripheral power wrong");
  a_stop_entry: assert property (
    r.st == ST_ACTIVE && stopInstr && !supplyLow && r.s2Misc[M_EXTN]
    |=> stopMode && r.refPin == $past(r.s2Pin))
    else $error("stop instruction ignored");
  a_wdt_run: assert property (
    1'b1 |=> watchdogRun == $past(watchdogEnable))
    else $error("watchdog run wrong");
  c_pin_recover: cover property (
    r.st == ST_RECOVER ##[1:40] r.st == ST_ACTIVE);
  c_wdt_irq: cover property (watchdogIrqReq);
  c_short_pulse: cover property (
    r.st == ST_STOP && diff == 8'h00 && r.cnt != 8'h00);
  c_ext_stop: cover property (stopMode ##1 sysReset);
endmodule

/* File: dv/rsr_pin_model.sv */
/*
  rsr_pin_model: far side of the controller's pins (reset pin, debug
  pin, gpio wake pins), driven as tasks called by the bench.
  assumes: the bench clock; every pin is always driven to a rail.
*/
`timescale 1ns/1ps

module rsr_pin_model (
  // clock
  input  wire logic clk,
  // pins
  output logic       extResetN,
  output logic       debugPin,
  output logic [7:0] gpioPin
);
  initial begin
    extResetN = 1'b1;
    debugPin  = 1'b1;
    gpioPin   = 8'h00;
  end

  task automatic resetPulse(input int cyc);
    @(posedge clk) extResetN <= 1'b0;
    repeat (cyc) @(posedge clk);
    extResetN <= 1'b1;
  endtask

  task automatic debugLow(input int cyc);
    @(posedge clk) debugPin <= 1'b0;
    repeat (cyc) @(posedge clk);
    debugPin <= 1'b1;
  endtask

  // cyc 0 leaves the pin flipped, else flips it back after cyc cycles
  task automatic pinFlip(input int idx, input int cyc);
    @(posedge clk) gpioPin[idx] <= ~gpioPin[idx];
    if (cyc > 0) begin
      repeat (cyc) @(posedge clk);
      gpioPin[idx] <= ~gpioPin[idx];
    end
  endtask
endmodule

/* File: dv/testbench.sv */
/*
  testbench: self-checking bench for rsr_ctrl over AXI4-Lite and pins.
  assumes: rsr_pkg timing constants; the pin model on the far side.
*/
`timescale 1ns/1ps

module testbench
  import rsr_pkg::*;
;
  typedef struct {
    bit          wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } rsr_row_s;

  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        brownoutLow, porLow, brownoutInSleepOption;
  logic        extResetN, debugPin, stopInstr, haltInstr, haltWake;
  logic        watchdogEnable, watchdogIrqMode, irqEnable, watchdogTimeout;
  logic        sysReset, cpuClockEn, brownoutEnable, watchdogRun;
  logic        stopMode, haltMode, watchdogIrqReq;
  logic [7:0]  gpioPin, periphPowerEn, portInputLatch;
  int          miscompares, testsRun, irqCount, recCnt;
  logic [31:0] rd;
  logic [1:0]  rr;

  rsr_ctrl i_dut (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .brownoutLow, .porLow,
    .brownoutInSleepOption, .extResetN, .debugPin, .gpioPin, .stopInstr,
    .haltInstr, .haltWake, .watchdogEnable, .watchdogIrqMode, .irqEnable,
    .watchdogTimeout, .sysReset, .cpuClockEn, .periphPowerEn,
    .brownoutEnable, .watchdogRun, .stopMode, .haltMode, .watchdogIrqReq,
    .portInputLatch);

  rsr_pin_model i_pins (.clk, .extResetN, .debugPin, .gpioPin);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares=%0d mismatches=%0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic giveUp(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
    conclude();
  endtask

  // sel: 0 cpu clock, 1 stop, 2 system reset, else halt
  task automatic waitSel(input int sel, input logic v, input int lim);
    logic s;
    int   n;
    n = 0;
    do begin
      @(posedge clk);
      case (sel)
        0: s = cpuClockEn;
        1: s = stopMode;
        2: s = sysReset;
        default: s = haltMode;
      endcase
      n++;
    end while (s !== v && n < lim);
    if (s !== v) giveUp(s, v);
  endtask

  task automatic axiWr(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r, input logic [3:0] s = 4'hF);
    int n;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) giveUp(n, 0);
  endtask

  task automatic axiRd(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) giveUp(n, 0);
  endtask

  // check cause flags, then clear them all
  task automatic expStat(input logic [3:0] e);
    axiRd(OFS_STAT, rd, rr);
    chk(rd, {28'h0, e});
    axiWr(OFS_STAT, 32'h0000_000F, rr);
    chk(rr, RESP_OKAY);
  endtask

  task automatic goStop;
    @(posedge clk) stopInstr <= 1'b1;
    @(posedge clk) stopInstr <= 1'b0;
    waitSel(1, 1'b1, 10);
  endtask

  // irq must not come before the recovery has run its course
  always @(posedge clk) begin
    recCnt <= stopMode ? 0 : recCnt + 1;
    if (watchdogIrqReq === 1'b1) begin
      irqCount <= irqCount + 1;
      chk(recCnt >= REC_CYC - 1, 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  rsr_row_s rows [10] = '{
    '{1, OFS_CTRL, 32'h0000_0703, 32'h0, RESP_OKAY},
    '{0, OFS_CTRL, 32'h0, 32'h0000_0703, RESP_OKAY},
    '{0, OFS_STAT, 32'h0, 32'h0000_0001, RESP_OKAY},
    '{1, OFS_STAT, 32'h0000_0001, 32'h0, RESP_OKAY},
    '{0, OFS_STAT, 32'h0, 32'h0, RESP_OKAY},
    '{0, OFS_MODE, 32'h0, 32'h0000_0002, RESP_OKAY},
    '{0, OFS_PIN, 32'h0, 32'h0, RESP_OKAY},
    '{1, 4'h2, 32'h0000_FFFF, 32'h0, RESP_SLVERR},
    '{0, 4'h2, 32'h0, 32'h0, RESP_SLVERR},
    '{0, OFS_CTRL, 32'h0, 32'h0000_0703, RESP_OKAY}};

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {brownoutLow, porLow, brownoutInSleepOption} = '0;
    {stopInstr, haltInstr, haltWake, watchdogEnable} = '0;
    {watchdogIrqMode, irqEnable, watchdogTimeout} = '0;
    {miscompares, testsRun, irqCount, recCnt} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    waitSel(0, 1'b1, 100);
    chk(sysReset, 0);
    chk(periphPowerEn, 8'hFF);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axiWr(rows[i].a, rows[i].d, rr);
      end else begin
        axiRd(rows[i].a, rd, rr);
        chk(rd, rows[i].e);
      end
      chk(rr, rows[i].r);
    end
    chk(periphPowerEn, 8'hF8);
    // pin wake: disabled pin, short pulse, then a real wake
    goStop();
    chk(cpuClockEn, 0);
    chk(periphPowerEn, 0);
    i_pins.pinFlip(2, 0);
    repeat (20) @(posedge clk);
    chk(stopMode, 1);
    chk(portInputLatch, 0);
    i_pins.pinFlip(0, 3);
    repeat (15) @(posedge clk);
    chk(stopMode, 1);
    expStat(4'h2);
    i_pins.pinFlip(1, 0);
    waitSel(1, 1'b0, 20);
    waitSel(0, 1'b1, 40);
    chk(portInputLatch, 8'h06);
    expStat(4'h2);
    // watchdog wake: reset mode, irq mode enabled, irq mode masked
    for (int m = 0; m < 3; m++) begin
      int irq0;
      irq0 = irqCount;
      watchdogEnable <= 1'b1;
      watchdogIrqMode <= (m != 0);
      irqEnable <= (m != 2);
      brownoutInSleepOption <= (m != 0);
      goStop();
      chk(watchdogRun, 1);
      chk(brownoutEnable, m != 0);
      @(posedge clk) watchdogTimeout <= 1'b1;
      repeat (3) @(posedge clk);
      watchdogTimeout <= 1'b0;
      waitSel(1, 1'b0, 20);
      chk(sysReset, 0);
      waitSel(0, 1'b1, 40);
      repeat (3) @(posedge clk);
      chk(irqCount - irq0, m == 1);
      expStat(4'h6);
    end
    watchdogEnable <= 1'b0;
    // reset pin and debug pin in stop
    for (int s = 0; s < 2; s++) begin
      goStop();
      if (s == 0) i_pins.resetPulse(4);
      else i_pins.debugLow(4);
      waitSel(2, 1'b1, 10);
      waitSel(0, 1'b1, 120);
      expStat(4'h8);
    end
    // supply dip in active mode
    @(posedge clk) brownoutLow <= 1'b1;
    porLow <= 1'b1;
    waitSel(2, 1'b1, 10);
    repeat (80) @(posedge clk);
    chk(sysReset, 1);
    chk(cpuClockEn, 0);
    brownoutLow <= 1'b0;
    porLow <= 1'b0;
    waitSel(0, 1'b1, 120);
    expStat(4'h1);
    // halt keeps peripherals, stops only the processor
    axiWr(OFS_CTRL, 32'h0000_0F00, rr);
    @(posedge clk) haltInstr <= 1'b1;
    @(posedge clk) haltInstr <= 1'b0;
    waitSel(3, 1'b1, 10);
    chk(cpuClockEn, 0);
    chk(periphPowerEn, 8'hF0);
    @(posedge clk) haltWake <= 1'b1;
    @(posedge clk) haltWake <= 1'b0;
    waitSel(0, 1'b1, 10);
    chk(haltMode, 0);
    // byte strobes: only the peripheral-disable byte is written
    axiWr(OFS_CTRL, 32'h0000_A5FF, rr, 4'h2);
    chk(rr, RESP_OKAY);
    axiRd(OFS_CTRL, rd, rr);
    chk(rd, 32'h0000_A500);
    chk(periphPowerEn, 8'h5A);
    conclude();
  end
endmodule
